// [hdl/csc_pkg.sv]
package csc_pkg;
    // register byte addresses on the bus
    localparam logic [3:0] CSC_ADDR_MAIN    = 4'h0;
    localparam logic [3:0] CSC_ADDR_CHANNEL = 4'h4;
    localparam logic [3:0] CSC_ADDR_TIMERS  = 4'h8;
    // fields of sense_control_main
    localparam int CSC_BIT_ENABLE   = 7;
    localparam int CSC_BIT_RANGE    = 6;
    localparam int CSC_LVL_HI       = 3;
    localparam int CSC_LVL_LO       = 2;
    localparam int CSC_BIT_DIR      = 1;
    localparam int CSC_BIT_EXT_SEL  = 0;
    localparam logic [7:0] CSC_MAIN_WMASK    = 8'hcd;
    localparam logic [7:0] CSC_CHANNEL_WMASK = 8'h0f;
    // timer routing register (bit0 timer_a_clock_source, bits 2:1 timer_b_clock_source)
    localparam int CSC_BIT_TA_SRC   = 0;
    localparam int CSC_TB_SRC_HI    = 2;
    localparam int CSC_TB_SRC_LO    = 1;
    localparam logic [7:0] CSC_TIMERS_WMASK  = 8'h07;
    localparam logic [7:0] CSC_RESET_VALUE   = 8'h00;
    localparam logic [1:0] CSC_TB_SRC_SENSE  = 2'h3;
    localparam logic [1:0] CSC_LEVEL_OFF     = 2'h0;
    localparam logic [3:0] CSC_LAST_CHANNEL  = 4'hb;
    localparam int CSC_CHANNELS = 12;
    localparam logic [1:0] CSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;
endpackage : csc_pkg

// [hdl/csc_sense_control.sv]
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// [RQ1] oscillator keeps running while enabled, sleep or not
// [RQ2] timer may count in sleep; evaluating change needs an awake part
// [RQ3] first timer is stopped while the part sleeps
// [RQ4] main bit 7 enables the sensing module
// [RQ5] main bit 6 picks high range (variable references) or low range
// [RQ6] low range level codes: off, low, medium, high
// [RQ7] high range codes 01..11 pick low, medium, high current
// [RQ8] high range code 00 is noise detection, oscillator on, no current
// [RQ9] read-only bit 1 shows oscillator direction, one when sourcing
// [RQ10] with external source, bit 0 picks oscillator or external pin
// [RQ11] internal source clocks first timer from instruction clock
// [RQ12] channel code ignored and no channel connected while disabled
// [RQ13] codes 0 to 11 connect the matching sensing input when enabled
// [RQ14] software must not write reserved channel codes 12 to 15
// [RQ15] unimplemented bits of both registers read as zero
// [RQ16] second timer source code 11 clocks it from the oscillator
// [RQ17] time base must come from the other timer
// [RQ18] oscillator output synchronised before use as count enable
// [RQ19] all writable bits clear to zero on every reset
module csc_sense_control
    import csc_pkg::*;
#(
    parameter int CHANNELS = CSC_CHANNELS
) (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write address
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // system state
    input  wire logic                sleep_active,
    input  wire logic                instr_clk_tick,
    // analog oscillator front end
    input  wire logic                osc_comparator_out,
    output logic                     osc_run,
    output logic                     reference_range_select,
    output logic [1:0]               current_level_select,
    output logic                     noise_detect_mode,
    output logic [CHANNELS-1:0]      channel_connect,
    // timer routing
    input  wire logic                timer_a_external_pin,
    output logic                     timer_a_count_en,
    output logic                     timer_b_count_en
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] sense_control_main;
    logic [7:0] sense_channel_select;
    logic [7:0] timer_routing;
    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       osc_sync1;
    logic       osc_sync2;
    logic       osc_prev;
    logic       pin_sync1;
    logic       pin_sync2;
    logic       pin_prev;
    logic       osc_rise;
    logic       pin_rise;
    logic       wr_fire;

    // channel code field of sense_channel_select
    localparam int CSC_CHAN_HI = 3;
    localparam int CSC_CHAN_LO = 0;

    // byte addresses of the three registers
    function automatic logic known_addr(input logic [3:0] a);
        return (a == CSC_ADDR_MAIN) || (a == CSC_ADDR_CHANNEL) || (a == CSC_ADDR_TIMERS);
    endfunction : known_addr

    // a cleared lowest strobe leaves the register untouched
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask);
        merge = w_strb[0] ? ((old & ~wmask) | (w_data[7:0] & wmask)) : old;
    endfunction : merge

    function automatic logic [1:0] level_of(input logic [7:0] ctrl);
        return ctrl[CSC_LVL_HI:CSC_LVL_LO];
    endfunction : level_of

    // code 00: off in the low range, noise detection in the high range
    function automatic logic level_is_zero(input logic [7:0] ctrl);
        return level_of(ctrl) == CSC_LEVEL_OFF;
    endfunction : level_is_zero

    // registers are one byte; the upper lanes always read zero
    function automatic logic [31:0] widen(input logic [7:0] value);
        return 32'(value);
    endfunction : widen

    function automatic logic [3:0] channel_of(input logic [7:0] sel);
        return sel[CSC_CHAN_HI:CSC_CHAN_LO];
    endfunction : channel_of

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data accepted in either order
    // held off while bvalid stands, so its set and clear never meet
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CSC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // unmapped address: error answer, nothing changes
            s_axi_bresp  <= known_addr(aw_addr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; direction bit is not stored, it mirrors the comparator
    // a write lands at the edge that raises bvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_control_main   <= CSC_RESET_VALUE; // RQ19
            sense_channel_select <= CSC_RESET_VALUE; // RQ19
            timer_routing        <= CSC_RESET_VALUE; // RQ19
        end else if (wr_fire) begin
            unique case (aw_addr)
                CSC_ADDR_MAIN:
                    sense_control_main <= merge(sense_control_main, CSC_MAIN_WMASK); // RQ4 RQ15
                CSC_ADDR_CHANNEL:
                    sense_channel_select <= merge(sense_channel_select,
                                                  CSC_CHANNEL_WMASK); // RQ15
                CSC_ADDR_TIMERS:
                    timer_routing <= merge(timer_routing, CSC_TIMERS_WMASK);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= CSC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= known_addr(s_axi_araddr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
                unique case (s_axi_araddr)
                    CSC_ADDR_MAIN: begin
                        s_axi_rdata <= widen(sense_control_main); // RQ15
                        // lags the pin by the two synchroniser stages
                        s_axi_rdata[CSC_BIT_DIR] <= osc_sync2; // RQ9
                    end
                    CSC_ADDR_CHANNEL:
                        s_axi_rdata <= widen(sense_channel_select); // RQ15
                    CSC_ADDR_TIMERS:
                        s_axi_rdata <= widen(timer_routing);
                    default:
                        s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator controls; sleep is deliberately not an input to these
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_run                <= 1'b0;
            reference_range_select <= 1'b0;
            current_level_select   <= CSC_LEVEL_OFF;
            noise_detect_mode      <= 1'b0;
        end else begin
            reference_range_select <= sense_control_main[CSC_BIT_RANGE]; // RQ5
            current_level_select   <= level_of(sense_control_main); // RQ6 RQ7
            // low range off code stops it; high range keeps it alive
            osc_run <= sense_control_main[CSC_BIT_ENABLE]
                       && (sense_control_main[CSC_BIT_RANGE]
                           || !level_is_zero(sense_control_main)); // RQ1 RQ6
            noise_detect_mode <= sense_control_main[CSC_BIT_ENABLE]
                                 && sense_control_main[CSC_BIT_RANGE]
                                 && level_is_zero(sense_control_main); // RQ8
        end
    end

    // one-hot pad connect, nothing for reserved codes or when disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_connect <= '0;
        end else begin
            channel_connect <= '0;
            if (sense_control_main[CSC_BIT_ENABLE]
                && channel_of(sense_channel_select) <= CSC_LAST_CHANNEL) begin // RQ12 RQ13
                channel_connect[channel_of(sense_channel_select)] <= 1'b1; // RQ13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; edge detect reads only the second stage
    // stages reset to the idle low level, so no false edge follows reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_sync1 <= 1'b0;
            osc_sync2 <= 1'b0;
            osc_prev  <= 1'b0;
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev  <= 1'b0;
        end else begin
            osc_sync1 <= osc_comparator_out; // RQ18
            osc_sync2 <= osc_sync1;
            osc_prev  <= osc_sync2;
            pin_sync1 <= timer_a_external_pin;
            pin_sync2 <= pin_sync1;
            pin_prev  <= pin_sync2;
        end
    end

    assign osc_rise = osc_sync2 && !osc_prev; // RQ18
    assign pin_rise = pin_sync2 && !pin_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_count_en <= 1'b0;
            timer_b_count_en <= 1'b0;
        end else begin
            // single-cycle pulses; sleep wins over every source of the first timer
            if (sleep_active) begin
                timer_a_count_en <= 1'b0; // RQ3
            end else if (!timer_routing[CSC_BIT_TA_SRC]) begin
                timer_a_count_en <= instr_clk_tick; // RQ11
            end else if (sense_control_main[CSC_BIT_EXT_SEL]) begin
                timer_a_count_en <= osc_rise; // RQ10
            end else begin
                timer_a_count_en <= pin_rise; // RQ10
            end
            // second timer keeps counting in sleep
            timer_b_count_en <= (timer_routing[CSC_TB_SRC_HI:CSC_TB_SRC_LO]
                                 == CSC_TB_SRC_SENSE) && osc_rise; // RQ16 RQ2
        end
    end

endmodule : csc_sense_control

// [tb/csc_pad_model.sv]
`timescale 1ns/10ps
module csc_pad_model (
    // clock and oscillator control
    input  wire logic       aclk,
    input  wire logic       osc_run,
    input  wire logic [3:0] half_period,
    // comparator towards the block
    output logic            osc_comparator_out
);
    logic [3:0] cnt = 4'h0;
    initial osc_comparator_out = 1'b0;
    // no sleep input: the pad keeps swinging while the part sleeps
    always @(posedge aclk) begin
        cnt <= (cnt >= half_period) ? 4'h0 : cnt + 4'h1;
        if (osc_run && cnt >= half_period) osc_comparator_out <= !osc_comparator_out;
    end
endmodule : csc_pad_model

// [tb/csc_sense_control_props.sv]
`timescale 1ns/10ps
module csc_sense_control_props
    import csc_pkg::*;
(
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // register bus
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic [3:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       s_axi_rvalid,
    // front end and timers
    input wire logic       sleep_active,
    input wire logic       osc_run,
    input wire logic       reference_range_select,
    input wire logic [1:0] current_level_select,
    input wire logic       noise_detect_mode,
    input wire logic       timer_a_count_en,
    input wire logic       timer_b_count_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
    chk_read_answer: assert property (ar_taken |=> s_axi_rvalid) else $error("read late");
    chk_bad_read: assert property (ar_taken ##0 s_axi_araddr == 4'hc |=>
        s_axi_rresp == CSC_RESP_SLVERR) else $error("unmapped read accepted");
    chk_write_answer: assert property (aw_taken |-> ##[1:2] s_axi_bvalid) else $error("write late");
    chk_noise_mode: assert property (noise_detect_mode |-> osc_run &&
        reference_range_select && current_level_select == 2'h0) else $error("noise fields");
    chk_low_off: assert property (!reference_range_select && current_level_select == 2'h0
        |-> !osc_run && !noise_detect_mode) else $error("low range off runs");
    chk_high_codes: assert property (reference_range_select && current_level_select != 2'h0
        |-> !noise_detect_mode) else $error("noise with current");
    chk_sleep_timer: assert property (sleep_active [*2] |-> !timer_a_count_en)
        else $error("first timer counts in sleep");
    chk_count_once: assert property (timer_b_count_en |=> !timer_b_count_en)
        else $error("edge counted twice");
endmodule : csc_sense_control_props
bind csc_sense_control csc_sense_control_props u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
    .s_axi_rvalid, .sleep_active, .osc_run, .reference_range_select, .current_level_select,
    .noise_detect_mode, .timer_a_count_en, .timer_b_count_en);

// [tb/csc_sense_control_tb_top.sv]
`timescale 1ns/10ps
module csc_sense_control_tb_top;
    import csc_pkg::*;
    logic        aclk = 0, aresetn = 0, sleep_active = 0, instr_clk_tick = 0, clr = 0, p_osc = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, p_pin = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, timer_a_external_pin = 0;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, half_period = 4'h1;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, current_level_select;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_run;
    logic        osc_comparator_out, reference_range_select, noise_detect_mode;
    logic        timer_a_count_en, timer_b_count_en;
    logic [11:0] channel_connect;
    logic [7:0]  m_reg [4] = '{default: 8'h00};
    logic [7:0]  wm [4] = '{CSC_MAIN_WMASK, CSC_CHANNEL_WMASK, CSC_TIMERS_WMASK, 8'h00};
    logic [2:0]  tmr_tab [5] = '{3'h6, 3'h1, 3'h1, 3'h7, 3'h2};
    int          err_count = 0, samples_checked = 0, seed = 78537;
    int          n_ta, n_tb, n_rise, n_pin, n_tick, cyc, e;
    always #5 aclk = ~aclk;
    csc_pad_model pads (.aclk, .osc_run, .half_period, .osc_comparator_out);
    csc_sense_control DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_active, .instr_clk_tick, .osc_comparator_out,
        .osc_run, .reference_range_select, .current_level_select, .noise_detect_mode,
        .channel_connect, .timer_a_external_pin, .timer_a_count_en, .timer_b_count_en);
    ////////////////////////////////////////////////////////////////////////////////
    // sparse ticks keep each window within one count of the model
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        timer_a_external_pin <= cyc[3];
        instr_clk_tick <= ($random(seed) & 7) == 0;
        p_osc <= osc_comparator_out;
        p_pin <= timer_a_external_pin;
        n_ta <= clr ? 0 : n_ta + int'(timer_a_count_en === 1'b1);
        n_tb <= clr ? 0 : n_tb + int'(timer_b_count_en === 1'b1);
        n_rise <= clr ? 0 : n_rise + int'(osc_comparator_out && !p_osc);
        n_pin <= clr ? 0 : n_pin + int'(timer_a_external_pin && !p_pin);
        n_tick <= clr ? 0 : n_tick + int'(instr_clk_tick);
    end
    function automatic logic osc_exp();
        return m_reg[0][7] && (m_reg[0][6] || m_reg[0][3:2] != 2'h0);
    endfunction : osc_exp
    function automatic logic ok(input logic [3:0] a);
        return a == CSC_ADDR_MAIN || a == CSC_ADDR_CHANNEL || a == CSC_ADDR_TIMERS;
    endfunction : ok
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] s);
        samples_checked++;
        if (s !== ex) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, s);
        end
    endtask : cmp
    task automatic cmp_cnt(input string nm, input int ex, input int s);
        samples_checked++;
        if (s > ex + 1 || s + 1 < ex) begin
            err_count++;
            $display("[ERR] %s expected %0d seen %0d", nm, ex, s);
        end
    endtask : cmp_cnt
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        if (ok(a)) m_reg[a[3:2]] = d & wm[a[3:2]];
        cmp("bresp", 32'(ok(a) ? CSC_RESP_OKAY : CSC_RESP_SLVERR), 32'(s_axi_bresp));
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        logic [31:0] ex, mk;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        ex = ok(a) ? {24'h0, m_reg[a[3:2]]} : 32'h0;
        // direction bit moves while the oscillator runs
        mk = (a == CSC_ADDR_MAIN && osc_exp()) ? 32'hffff_fffd : 32'hffff_ffff;
        if (a == CSC_ADDR_MAIN) ex[1] = osc_comparator_out;
        cmp("rdata", ex & mk, s_axi_rdata & mk);
        cmp("rresp", 32'(ok(a) ? CSC_RESP_OKAY : CSC_RESP_SLVERR), 32'(s_axi_rresp));
        @(posedge aclk);
    endtask : rd
    task automatic chk_out();
        logic [7:0] m, c;
        m = m_reg[0];
        c = m_reg[1];
        repeat (2) @(posedge aclk);
        #1;
        cmp("front_end", 32'({osc_exp(), m[6], m[3:2], m[7] && m[6] && m[3:2] == 2'h0,
            (m[7] && c < 8'd12) ? 12'(1 << c) : 12'h0}), 32'({osc_run, reference_range_select,
            current_level_select, noise_detect_mode, channel_connect}));
        @(posedge aclk);
    endtask : chk_out
    task automatic win();
        repeat (8) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (200) @(posedge aclk);
        #1;
        cmp_cnt("timer_b", m_reg[2][2:1] == CSC_TB_SRC_SENSE ? n_rise : 0, n_tb);
        e = sleep_active ? 0 : !m_reg[2][0] ? n_tick : m_reg[0][0] ? n_rise : n_pin;
        cmp_cnt("timer_a", e, n_ta);
        @(posedge aclk);
    endtask : win
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) rd(4'(a));
        wr(4'hc, 8'hff);
        wr(CSC_ADDR_MAIN, 8'h80);
        for (int c = 0; c < 12; c++) begin
            wr(CSC_ADDR_CHANNEL, {4'($random(seed)), 4'(c)});
            chk_out();
            rd(CSC_ADDR_CHANNEL);
        end
        for (int i = 0; i < 16; i++) begin
            wr(CSC_ADDR_MAIN, {i[3], i[2], 2'($random(seed)), i[1:0], 2'($random(seed))});
            chk_out();
            rd(CSC_ADDR_MAIN);
        end
        for (int k = 0; k < 5; k++) begin
            sleep_active <= k == 3;
            half_period <= (k == 4) ? 4'h5 : 4'h1;
            wr(CSC_ADDR_MAIN, (k == 1) ? 8'hcd : 8'hcc);
            wr(CSC_ADDR_TIMERS, {5'h0, tmr_tab[k]});
            rd(CSC_ADDR_TIMERS);
            win();
        end
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        m_reg = '{default: 8'h00};
        // let the direction synchroniser refill before the first read
        repeat (4) @(posedge aclk);
        for (int a = 0; a < 16; a += 4) rd(4'(a));
        chk_out();
        print_verdict();
    end
    initial begin
        #200_000;
        err_count++;
        print_verdict();
    end
endmodule : csc_sense_control_tb_top
